// [hdl/pxe_pkg.sv]
// package for the sixteen-bit i2c port expander target
// assumes a single 100 MHz reference clock samples the i2c pins
`default_nettype none
package pxe_pkg;
    localparam logic [3:0] PXE_ADDR_PREFIX = 4'h4;      // fixed address prefix, bits 7..4
    localparam int PXE_PREFIX_MSB = 7;
    localparam int PXE_PREFIX_LSB = 4;
    localparam int PXE_SEL_MSB = 3;
    localparam int PXE_SEL_LSB = 1;
    localparam int PXE_RW_BIT = 0;
    localparam logic [2:0] PXE_BIT_LAST = 3'h7;         // bit counter value of the eighth bit
    localparam logic [15:0] PXE_PORT_RESET = 16'hFFFF;  // port lines come up high

    // link state, gray along start -> address -> ack -> data
    typedef enum logic [2:0] {
        PXE_IDLE = 3'b000,
        PXE_ADDR = 3'b001,
        PXE_ADDR_ACK = 3'b011,
        PXE_WDATA = 3'b010,
        PXE_WACK = 3'b110,
        PXE_RDATA = 3'b111,
        PXE_RACK = 3'b101
    } pxe_state_t;

    // synchronised view of the two bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } pxe_bus_t;
endpackage
`default_nettype wire

// [hdl/pxe_expander.sv]
// sixteen-bit quasi-bidirectional port expander behind an i2c target
// assumes scl and sda arrive asynchronously; a wired bus resolves the enables
`default_nettype none
module pxe_expander
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe_n,
    input wire logic i_addr_select_hi,
    input wire logic i_addr_select_mid,
    input wire logic i_addr_select_lo,
    input wire logic [7:0] i_low_port_lines,
    input wire logic [7:0] i_high_port_lines,
    output logic [7:0] o_low_port_lines,
    output logic [7:0] o_high_port_lines,
    output logic o_int,
    output logic o_int_oe_n
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    pxe_pkg::pxe_bus_t bus_meta;
    pxe_pkg::pxe_bus_t bus_sync;
    pxe_pkg::pxe_bus_t bus_prev;
    logic [2:0] sel_meta;
    logic [2:0] sel_sync;
    logic [15:0] pin_meta;
    logic [15:0] pin_sync;

    // two flops on every pin from outside the clock domain
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            bus_meta <= '{scl: 1'b1, sda: 1'b1};
            bus_sync <= '{scl: 1'b1, sda: 1'b1};
            bus_prev <= '{scl: 1'b1, sda: 1'b1};
            sel_meta <= 3'h0;
            sel_sync <= 3'h0;
            pin_meta <= pxe_pkg::PXE_PORT_RESET;
            pin_sync <= pxe_pkg::PXE_PORT_RESET;
        end
        else
        begin
            bus_meta <= '{scl: i_scl, sda: i_sda};
            bus_sync <= bus_meta;
            bus_prev <= bus_sync;
            sel_meta <= {i_addr_select_hi, i_addr_select_mid, i_addr_select_lo};
            sel_sync <= sel_meta;
            pin_meta <= {i_high_port_lines, i_low_port_lines};
            pin_sync <= pin_meta;
        end
    end

    // ************************************************************
    // bus event decode
    // ************************************************************
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    // start and stop are sda edges while scl stays high
    assign scl_rise = bus_sync.scl & ~bus_prev.scl;
    assign scl_fall = ~bus_sync.scl & bus_prev.scl;
    assign start_seen = bus_sync.scl & bus_prev.scl & bus_prev.sda & ~bus_sync.sda;
    assign stop_seen = bus_sync.scl & bus_prev.scl & ~bus_prev.sda & bus_sync.sda;

    // ************************************************************
    // link state machine
    // ************************************************************
    pxe_pkg::pxe_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] rx_byte;
    logic byte_done;
    logic addr_hit;
    logic high_half;
    logic [7:0] low_hold;
    logic [7:0] tx_byte;
    logic drive_low;
    logic master_nack;
    logic [15:0] port_out;
    logic port_access;
    logic rw_read;
    logic ack_end;
    logic next_half;
    logic [7:0] next_byte;

    assign rx_byte = {shift[6:0], bus_sync.sda};
    assign byte_done = scl_rise && (bit_cnt == pxe_pkg::PXE_BIT_LAST);
    // general call (all zero) can never match the fixed prefix
    assign addr_hit = (rx_byte[pxe_pkg::PXE_PREFIX_MSB:pxe_pkg::PXE_PREFIX_LSB]
                       == pxe_pkg::PXE_ADDR_PREFIX)
                      && (rx_byte[pxe_pkg::PXE_SEL_MSB:pxe_pkg::PXE_SEL_LSB]
                       == sel_sync);
    // the falling edge that closes any ack slot opens the next byte
    assign ack_end = scl_fall && (bit_cnt == 3'h1)
                     && (state == pxe_pkg::PXE_ADDR_ACK || state == pxe_pkg::PXE_WACK
                         || state == pxe_pkg::PXE_RACK);
    // read byte for the slot being opened: low port after the address, then alternate
    assign next_half = (state == pxe_pkg::PXE_RACK) ? ~high_half : high_half;
    assign next_byte = next_half ? pin_sync[15:8] : pin_sync[7:0];

    // state, bit counter and byte-pair position
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state <= pxe_pkg::PXE_IDLE;
            bit_cnt <= 3'h0;
            shift <= 8'h00;
            high_half <= 1'b0;
            master_nack <= 1'b0;
            rw_read <= 1'b0;
        end
        else if (start_seen)
        begin
            // a repeated start restarts the address phase
            state <= pxe_pkg::PXE_ADDR;
            bit_cnt <= 3'h0;
            high_half <= 1'b0;
        end
        else if (stop_seen)
        begin
            state <= pxe_pkg::PXE_IDLE;
        end
        else
        begin
            if (scl_rise)
            begin
                shift <= rx_byte;
                bit_cnt <= bit_cnt + 3'h1;
            end
            unique case (state)
                pxe_pkg::PXE_ADDR:
                begin
                    if (byte_done)
                    begin
                        // direction is kept here: shift moves on at the ack bit
                        rw_read <= rx_byte[pxe_pkg::PXE_RW_BIT];
                        // mismatch falls back to idle and waits for a start
                        state <= addr_hit ? pxe_pkg::PXE_ADDR_ACK
                                          : pxe_pkg::PXE_IDLE;
                    end
                end
                pxe_pkg::PXE_WDATA, pxe_pkg::PXE_RDATA:
                begin
                    if (byte_done)
                    begin
                        state <= rw_read ? pxe_pkg::PXE_RACK : pxe_pkg::PXE_WACK;
                    end
                end
                pxe_pkg::PXE_ADDR_ACK, pxe_pkg::PXE_WACK, pxe_pkg::PXE_RACK:
                begin
                    if (scl_rise)
                    begin
                        master_nack <= bus_sync.sda;
                    end
                    if (ack_end)
                    begin
                        bit_cnt <= 3'h0;
                        high_half <= high_half ^ (state != pxe_pkg::PXE_ADDR_ACK);
                        // we pull our own ack slots low, so a nack is the master's
                        // read end; the master follows with a stop
                        state <= master_nack ? pxe_pkg::PXE_IDLE
                               : rw_read ? pxe_pkg::PXE_RDATA
                                         : pxe_pkg::PXE_WDATA;
                    end
                end
                default:
                begin
                    state <= pxe_pkg::PXE_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // port data path
    // ************************************************************
    // write pairs: first byte held, the second byte's ack commits all sixteen lines
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            low_hold <= 8'h00;
            port_out <= pxe_pkg::PXE_PORT_RESET;
        end
        else if (state == pxe_pkg::PXE_WDATA && byte_done && !high_half)
        begin
            low_hold <= rx_byte;
        end
        else if (state == pxe_pkg::PXE_WACK && scl_rise && high_half)
        begin
            // shift still holds the high byte here; the ack bit lands after this edge
            port_out <= {shift, low_hold};
        end
    end
    assign o_low_port_lines = port_out[7:0];
    assign o_high_port_lines = port_out[15:8];

    // read byte is captured at the falling edge that opens each data byte
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tx_byte <= 8'hFF;
        end
        else if (ack_end)
        begin
            tx_byte <= next_byte;
        end
        else if (scl_fall && state == pxe_pkg::PXE_RDATA)
        begin
            tx_byte <= {tx_byte[6:0], 1'b1};                              // msb first
        end
    end

    // sda pull-low: acks in write/address phase, data zeros in read phase
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            drive_low <= 1'b0;
        end
        else if (start_seen || stop_seen)
        begin
            drive_low <= 1'b0;
        end
        else if (ack_end)
        begin
            // closing an ack opens the next read byte with its top bit
            drive_low <= rw_read && !master_nack && !next_byte[7];
        end
        else if (scl_fall)
        begin
            unique case (state)
                pxe_pkg::PXE_ADDR_ACK, pxe_pkg::PXE_WACK: drive_low <= (bit_cnt == 3'h0);
                // tx_byte shifts on this same edge, so bit 6 is the next bit out
                pxe_pkg::PXE_RDATA: drive_low <= !tx_byte[6];
                default: drive_low <= 1'b0;
            endcase
        end
    end

    assign o_sda = 1'b0;
    assign o_sda_oe_n = ~drive_low;

    // ************************************************************
    // interrupt on input change
    // ************************************************************
    logic [15:0] int_ref;
    logic int_active;
    // access clears at the data ack: rising scl in read, falling in write
    assign port_access = (state == pxe_pkg::PXE_RACK && scl_rise)
                         || (state == pxe_pkg::PXE_WACK && scl_fall);

    // reference snapshot taken at every access; a difference on any line latched high pulls the interrupt line low
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            int_ref <= pxe_pkg::PXE_PORT_RESET;
        end
        else if (port_access)
        begin
            int_ref <= pin_sync;
        end
    end
    // level back to the snapshot clears it by itself
    assign int_active = |((int_ref ^ pin_sync) & port_out);
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_int_oe_n <= 1'b1;
        end
        else
        begin
            o_int_oe_n <= ~(int_active && !port_access);
        end
    end
    assign o_int = 1'b0;
endmodule // pxe_expander
`default_nettype wire

// [tb/pxe_expander_asserts.sv]
// assertions on the pins of the port expander
// assumes it is bound into pxe_expander and sees only its ports
`default_nettype none
module pxe_expander_asserts
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic o_sda,
    input wire logic o_sda_oe_n,
    input wire logic [7:0] o_low_port_lines,
    input wire logic [7:0] o_high_port_lines,
    input wire logic o_int,
    input wire logic o_int_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // pin properties
    // ****
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    // all lines latched low leaves no input that could raise an interrupt
    sequence s_all_out;
        ({o_high_port_lines, o_low_port_lines} == 16'h0000) [*3];
    endsequence
    sequence s_pull_held;
        !o_sda_oe_n [*5];
    endsequence
    property p_rst_out;
        $fell(i_rst) |-> {o_high_port_lines, o_low_port_lines} == 16'hffff && o_sda_oe_n;
    endproperty
    property p_sda_od;
        o_sda == 1'b0;
    endproperty
    property p_int_od;
        o_int == 1'b0;
    endproperty
    // data moves only in the low phase, else it would fake a start or stop
    property p_drive_edge;
        $changed(o_sda_oe_n) |-> !$past(i_scl);
    endproperty
    property p_port_commit;
        $changed({o_high_port_lines, o_low_port_lines}) |-> $past(i_scl);
    endproperty
    property p_int_quiet;
        s_all_out |-> o_int_oe_n;
    endproperty
    property p_ack_hold;
        $fell(o_sda_oe_n) |-> s_pull_held;
    endproperty
    property p_rel_hold;
        $rose(o_sda_oe_n) |=> o_sda_oe_n [*4];
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("ports not at reset value");
    a_sda_od: assert property (p_sda_od) else $error("data pin driven high");
    a_int_od: assert property (p_int_od) else $error("interrupt pin driven high");
    a_drive_edge: assert property (p_drive_edge) else $error("data moved in high phase");
    a_port_commit: assert property (p_port_commit) else $error("ports moved off commit");
    a_int_quiet: assert property (p_int_quiet) else $error("interrupt with no inputs");
    a_ack_hold: assert property (p_ack_hold) else $error("pull released too soon");
    a_rel_hold: assert property (p_rel_hold) else $error("release not held");
endmodule // pxe_expander_asserts
bind pxe_expander pxe_expander_asserts u_pxe_expander_asserts
(.i_ref_clk, .i_rst, .i_scl, .o_sda, .o_sda_oe_n,
.o_low_port_lines, .o_high_port_lines, .o_int, .o_int_oe_n);
`default_nettype wire

// [tb/pxe_master.sv]
// bus master model for the two wired i2c lines
// assumes the bench resolves the wired data line with a pull-up
`default_nettype none
module pxe_master
(
    input wire logic i_ref_clk,
    input wire logic i_sda,
    output var pxe_pkg::pxe_bus_t o_bus
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // bus phases, 80 ns per bit
    // ****
    // clock stands still high between frames, data released
    initial o_bus = '1;
    task automatic quarter();
        repeat (2) @(posedge i_ref_clk);
    endtask
    task automatic start();
        quarter();
        o_bus.sda <= 1'b0;
        quarter();
        o_bus.scl <= 1'b0;
    endtask
    // data set in the low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        quarter();
        o_bus.sda <= b;
        quarter();
        o_bus.scl <= 1'b1;
        quarter();
        r = i_sda;
        quarter();
        o_bus.scl <= 1'b0;
    endtask
    task automatic stop();
        quarter();
        o_bus.sda <= 1'b0;
        quarter();
        o_bus.scl <= 1'b1;
        quarter();
        o_bus.sda <= 1'b1;
        quarter();
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // last byte is refused with a high ack slot
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule // pxe_master
`default_nettype wire

// [tb/pxe_expander_tb_top.sv]
// self-checking bench for the sixteen-bit port expander
// assumes pxe_master as bus partner and the bound checker
`default_nettype none
module pxe_expander_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] sel = 3'h0;
    logic [15:0] pins = 16'hffff;
    logic [15:0] latch = 16'hffff;
    logic [15:0] last = 16'hffff;
    logic [7:0] seed = 8'h5a;
    logic [7:0] and_m = 8'hff;
    logic [7:0] or_m = 8'h00;
    logic sda_oe_n;
    logic int_oe_n;
    logic [15:0] port;
    pxe_pkg::pxe_bus_t bus;
    wire sda_w;
    int n_errors = 0;
    int comparisons = 0;
    logic [15:0] q_port[$];
    assign sda_w = bus.sda & sda_oe_n;
    pxe_master u_pxe_master (.i_ref_clk(clk), .i_sda(sda_w), .o_bus(bus));
    pxe_expander u_pxe_expander (.i_ref_clk(clk), .i_rst(rst), .i_scl(bus.scl),
        .i_sda(sda_w), .o_sda(), .o_sda_oe_n(sda_oe_n), .i_addr_select_hi(sel[2]),
        .i_addr_select_mid(sel[1]), .i_addr_select_lo(sel[0]),
        .i_low_port_lines(pins[7:0]), .i_high_port_lines(pins[15:8]),
        .o_low_port_lines(port[7:0]), .o_high_port_lines(port[15:8]),
        .o_int(), .o_int_oe_n(int_oe_n));
    // ****
    // helpers
    // ****
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk_word(input string what, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_bit(input string what, input logic e, input logic g);
        chk_word(what, {15'h0000, e}, {15'h0000, g});
    endtask
    // bounded wait; a level never reached ends the run
    task automatic wait_int(input logic lvl);
        for (int k = 0; k < 60 && int_oe_n !== lvl; k++) @(posedge clk);
        chk_bit("interrupt", lvl, int_oe_n);
        if (int_oe_n !== lvl) close_out();
    endtask
    // one framed transfer; a write commit is noted before its last bit goes out
    task automatic xfer(input logic [7:0] a, input logic acked, input int n);
        logic ack;
        logic [7:0] d;
        logic [7:0] lo;
        u_pxe_master.start();
        u_pxe_master.send(a, ack);
        chk_bit("address ack", acked, ack);
        for (int i = 0; i < n; i++)
        begin
            if (a[0])
            begin
                u_pxe_master.recv(i == n - 1, d);
                chk_word("read byte", {8'h00, i[0] ? pins[15:8] : pins[7:0]}, {8'h00, d});
            end
            else
            begin
                seed = lfsr(seed);
                d = (seed & and_m) | or_m;
                lo = i[0] ? lo : d;
                if (i[0] && acked && {d, lo} !== latch) q_port.push_back({d, lo});
                latch = (i[0] && acked) ? {d, lo} : latch;
                u_pxe_master.send(d, ack);
                chk_bit("data ack", acked, ack);
            end
        end
        u_pxe_master.stop();
    endtask
    // ****
    // clock, watchdog, port monitor, main sequence
    // ****
    initial
    begin
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        n_errors++;
        close_out();
    end
    // each port change takes the oldest noted commit
    always @(posedge clk)
    begin
        if (!rst && port !== last)
        begin
            last = port;
            chk_word("port", q_port.size() ? q_port.pop_front() : ~port, port);
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        for (int s = 0; s < 8; s++)
        begin
            sel <= s[2:0];
            repeat (4) @(posedge clk);
            xfer({4'h4, s[2:0] ^ 3'h1, 1'b0}, 1'b0, 2);
            xfer({4'h4 ^ (4'h1 << s[1:0]), s[2:0], 1'b0}, 1'b0, 2);
            xfer({4'h4, s[2:0], 1'b0}, 1'b1, 2);
        end
        xfer(8'h00, 1'b0, 2);
        $display("test address done");
        xfer({4'h4, sel, 1'b0}, 1'b1, 7);
        and_m = 8'h00;
        xfer({4'h4, sel, 1'b0}, 1'b1, 2);
        // all lines latched low: input edges must not raise the interrupt
        pins <= 16'h0000;
        repeat (6) @(posedge clk);
        chk_bit("interrupt", 1'b1, int_oe_n);
        pins <= 16'hffff;
        or_m = 8'hff;
        xfer({4'h4, sel, 1'b0}, 1'b1, 2);
        $display("test write done");
        for (int k = 0; k < 3; k++)
        begin
            seed = lfsr(seed);
            pins <= {seed, ~seed};
            repeat (4) @(posedge clk);
            xfer({4'h4, sel, 1'b1}, 1'b1, 4);
        end
        $display("test read done");
        pins <= pins ^ 16'h0100;
        wait_int(1'b0);
        pins <= pins ^ 16'h0100;
        wait_int(1'b1);
        pins <= pins ^ 16'h0004;
        wait_int(1'b0);
        xfer({4'h4, sel, 1'b1}, 1'b1, 2);
        wait_int(1'b1);
        $display("test interrupt done");
        chk_word("pending commits", 16'h0000, 16'(q_port.size()));
        close_out();
    end
endmodule // pxe_expander_tb_top
`default_nettype wire
